// [inc/pin_suspend_config_defs.vh]
// Constants for the pin and suspend configuration block
`ifndef PIN_SUSPEND_CONFIG_DEFS_VH
`define PIN_SUSPEND_CONFIG_DEFS_VH

// ==========================================================
// Register offsets
`define OFS_MODEM_READY_PIN_CFG 8'h2D
`define OFS_DATA_PIN_CFG 8'h2E
`define OFS_SUSPEND_LEVEL_UPPER 8'h2F
`define OFS_SUSPEND_LEVEL_LOWER 8'h30
`define OFS_SUSPEND_DRIVE_UPPER 8'h31
`define OFS_SUSPEND_DRIVE_LOWER 8'h32

// ==========================================================
// Reset value of every configuration byte
`define CFG_RESET 8'h00

// ==========================================================
// Field positions
`define BIT_PULLUP 7
`define BIT_PULLDOWN 6
`define BIT_RX_WAKE 5
`define BIT_TX_PUSHPULL 0
`define BIT_USE_SUSPEND 7
`define FUNC_HI 1
`define FUNC_LO 0

// Function select codes
`define FUNC_INPUT 2'h0
`define FUNC_OPEN_DRAIN 2'h1
`define FUNC_PUSH_PULL 2'h2

// ==========================================================
// Pin index in the ten-pin vector
`define PIN_CLOCK_OUT 0
`define PIN_REQUEST_TO_SEND 1
`define PIN_CLEAR_TO_SEND 2
`define PIN_HALF_DUPLEX_AUX 3
`define PIN_CARRIER_DETECT 4
`define PIN_RING_INDICATOR 5
`define PIN_TERMINAL_READY 6
`define PIN_MODEM_READY 7
`define PIN_TX_TOGGLE 8
`define PIN_RX_TOGGLE 9
`define NUM_PINS 10

`endif

// [hw/pin_drive_cell.v]
// Output driver decode for one pin: level and drive type to value and enable
`default_nettype none

module pin_drive_cell (
    input wire level,      // Wanted logic level
    input wire open_drain, // 1 open-drain, 0 push-pull
    output wire pad_out,   // Value on the pad when enabled
    output wire pad_oe     // High while the pad is driven
);

    // Open-drain only pulls low; push-pull drives both levels
    assign pad_out = open_drain ? 1'b0 : level;
    assign pad_oe = open_drain ? ~level : 1'b1;

endmodule // pin_drive_cell

`default_nettype wire

// [hw/pin_suspend_config.v]
// Pin function, pull and suspend drive configuration for one serial channel
`default_nettype none
`include "pin_suspend_config_defs.vh"

module pin_suspend_config (
    input wire CLOCK,                  // Core clock, 100 MHz
    input wire RESET,                  // Synchronous reset, active high
    input wire CE,                     // Clock enable, freezes state when low
    input wire CFG_WR,                 // Config byte write strobe
    input wire CFG_RD,                 // Config byte read strobe
    input wire [7:0] CFG_ADDR,         // Config byte offset
    input wire [7:0] CFG_WDATA,        // Config write data
    output reg [7:0] CFG_RDATA,        // Config read data
    input wire SUSPENDED,              // Link is in suspend
    input wire GLOBAL_WAKE_EN,         // Remote wakeup enabled by host
    input wire MODEM_READY_GPIO_OUT,   // GPIO output value for modem-ready
    input wire [9:0] NORM_OUT,         // Normal-function values, other pins
    input wire [9:0] NORM_OE,          // Normal-function enables, other pins
    input wire TX_DATA,                // Serial transmit data
    input wire MODEM_READY_IN_PIN,     // Modem-ready pad input level
    input wire RX_DATA_PIN,            // Receive data pad input level
    output reg [9:0] PIN_OUT,          // Pad values of the ten GPIO pins
    output reg [9:0] PIN_OE,           // Pad enables of the ten GPIO pins
    output reg MODEM_READY_PULLUP,     // Modem-ready pull-up on
    output reg MODEM_READY_PULLDOWN,   // Modem-ready pull-down on
    output reg MODEM_READY_LEVEL,      // Synchronised modem-ready level
    output reg RX_PULLUP,              // Receive pin pull-up on
    output reg RX_PULLDOWN,            // Receive pin pull-down on
    output reg RX_DATA,                // Synchronised receive data
    output reg REMOTE_WAKE_REQ,        // One-cycle wakeup request pulse
    output reg TX_PIN_OUT,             // Transmit pad value
    output reg TX_PIN_OE               // Transmit pad enable
);

    // ==========================================================
    // Configuration bytes
    reg [7:0] modem_ready_pin_cfg_ff;
    reg [7:0] data_pin_cfg_ff;
    reg [7:0] suspend_level_upper_ff;
    reg [7:0] suspend_level_lower_ff;
    reg [7:0] suspend_drive_upper_ff;
    reg [7:0] suspend_drive_lower_ff;

    // Input synchronisers and edge history
    reg mr_meta_ff;
    reg mr_sync_ff;
    reg rx_meta_ff;
    reg rx_sync_ff;
    reg rx_prev_ff;

    wire [1:0] mr_func;
    wire mr_is_input;
    wire use_suspend;
    wire apply_suspend;
    wire [9:0] susp_level;
    wire [9:0] susp_mode;
    wire [9:0] susp_out;
    wire [9:0] susp_oe;
    wire mr_norm_out;
    wire mr_norm_oe;
    wire tx_out;
    wire tx_oe;
    reg [9:0] nxt_pin_out;
    reg [9:0] nxt_pin_oe;
    reg [7:0] nxt_rdata;

    // ==========================================================
    // Read decode of the configuration bytes
    function [7:0] cfg_read;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_MODEM_READY_PIN_CFG: cfg_read = modem_ready_pin_cfg_ff;
                `OFS_DATA_PIN_CFG: cfg_read = data_pin_cfg_ff;
                `OFS_SUSPEND_LEVEL_UPPER: cfg_read = suspend_level_upper_ff;
                `OFS_SUSPEND_LEVEL_LOWER: cfg_read = suspend_level_lower_ff;
                `OFS_SUSPEND_DRIVE_UPPER: cfg_read = suspend_drive_upper_ff;
                `OFS_SUSPEND_DRIVE_LOWER: cfg_read = suspend_drive_lower_ff;
                default: cfg_read = 8'h00;
            endcase
        end
    endfunction

    // ==========================================================
    // Register writes; every byte resets to zero
    always @(posedge CLOCK) begin
        if (RESET) begin
            modem_ready_pin_cfg_ff <= `CFG_RESET;
            data_pin_cfg_ff <= `CFG_RESET;
            suspend_level_upper_ff <= `CFG_RESET;
            suspend_level_lower_ff <= `CFG_RESET;
            suspend_drive_upper_ff <= `CFG_RESET;
            suspend_drive_lower_ff <= `CFG_RESET;
        end else if (CE && CFG_WR) begin
            // Bytes are stored whole; software keeps reserved bits zero
            case (CFG_ADDR)
                `OFS_MODEM_READY_PIN_CFG: begin
                    modem_ready_pin_cfg_ff <= CFG_WDATA;
                end
                `OFS_DATA_PIN_CFG: begin
                    data_pin_cfg_ff <= CFG_WDATA;
                end
                `OFS_SUSPEND_LEVEL_UPPER: begin
                    suspend_level_upper_ff <= CFG_WDATA;
                end
                `OFS_SUSPEND_LEVEL_LOWER: begin
                    suspend_level_lower_ff <= CFG_WDATA;
                end
                `OFS_SUSPEND_DRIVE_UPPER: begin
                    suspend_drive_upper_ff <= CFG_WDATA;
                end
                `OFS_SUSPEND_DRIVE_LOWER: begin
                    suspend_drive_lower_ff <= CFG_WDATA;
                end
                default: begin
                    modem_ready_pin_cfg_ff <= modem_ready_pin_cfg_ff;
                end
            endcase
        end
    end

    // Read data, registered, zero for unmapped offsets
    always @* begin
        nxt_rdata = CFG_RD ? cfg_read(CFG_ADDR) : CFG_RDATA;
    end

    always @(posedge CLOCK) begin
        if (RESET) begin
            CFG_RDATA <= 8'h00;
        end else if (CE) begin
            CFG_RDATA <= nxt_rdata;
        end
    end

    // ==========================================================
    // Two-stage synchronisers for pad inputs
    always @(posedge CLOCK) begin
        if (RESET) begin
            mr_meta_ff <= 1'b0;
            mr_sync_ff <= 1'b0;
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else if (CE) begin
            mr_meta_ff <= MODEM_READY_IN_PIN;
            mr_sync_ff <= mr_meta_ff;
            rx_meta_ff <= RX_DATA_PIN;
            rx_sync_ff <= rx_meta_ff;
            rx_prev_ff <= rx_sync_ff;
        end
    end

    // ==========================================================
    // Modem-ready normal function decode
    assign mr_func = modem_ready_pin_cfg_ff[`FUNC_HI:`FUNC_LO];
    // Invalid code 11 is left as an input so the pad is never fought
    assign mr_is_input = (mr_func != `FUNC_OPEN_DRAIN) &&
                         (mr_func != `FUNC_PUSH_PULL);

    pin_drive_cell u_mr_norm (
        .level(MODEM_READY_GPIO_OUT),
        .open_drain(mr_func == `FUNC_OPEN_DRAIN),
        .pad_out(mr_norm_out),
        .pad_oe(mr_norm_oe)
    );

    // ==========================================================
    // Suspend override gates every suspend setting
    assign use_suspend = suspend_drive_lower_ff[`BIT_USE_SUSPEND];
    assign apply_suspend = SUSPENDED && use_suspend;

    // Level vector from both level bytes
    assign susp_level = {
        suspend_level_upper_ff[7],
        suspend_level_upper_ff[6],
        suspend_level_lower_ff[5],
        suspend_level_lower_ff[4],
        suspend_level_lower_ff[3],
        suspend_level_lower_ff[2],
        suspend_level_upper_ff[3],
        suspend_level_upper_ff[2],
        suspend_level_upper_ff[1],
        suspend_level_upper_ff[0]
    };

    // Drive-mode vector, same bit positions as the level bytes
    assign susp_mode = {
        suspend_drive_upper_ff[7],
        suspend_drive_upper_ff[6],
        suspend_drive_lower_ff[5],
        suspend_drive_lower_ff[4],
        suspend_drive_lower_ff[3],
        suspend_drive_lower_ff[2],
        suspend_drive_upper_ff[3],
        suspend_drive_upper_ff[2],
        suspend_drive_upper_ff[1],
        suspend_drive_upper_ff[0]
    };

    // One driver decode per pin for its suspend state
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_PINS; gi = gi + 1) begin : g_susp
            pin_drive_cell u_cell (
                .level(susp_level[gi]),
                .open_drain(susp_mode[gi]),
                .pad_out(susp_out[gi]),
                .pad_oe(susp_oe[gi])
            );
        end
    endgenerate

    // Pin selection between normal function and suspend state
    always @* begin
        nxt_pin_out = NORM_OUT;
        nxt_pin_oe = NORM_OE;
        // An input pin is never driven, so its pulls are not fought
        nxt_pin_out[`PIN_MODEM_READY] = mr_norm_out && !mr_is_input;
        nxt_pin_oe[`PIN_MODEM_READY] = mr_norm_oe && !mr_is_input;
        if (apply_suspend) begin
            nxt_pin_out = susp_out;
            nxt_pin_oe = susp_oe;
        end
    end

    // ==========================================================
    // Transmit data driver, never touched by suspend bytes
    pin_drive_cell u_tx (
        .level(TX_DATA),
        .open_drain(~data_pin_cfg_ff[`BIT_TX_PUSHPULL]),
        .pad_out(tx_out),
        .pad_oe(tx_oe)
    );

    // ==========================================================
    // Registered outputs
    always @(posedge CLOCK) begin
        if (RESET) begin
            PIN_OUT <= 10'h000;
            PIN_OE <= 10'h000;
            MODEM_READY_PULLUP <= 1'b0;
            MODEM_READY_PULLDOWN <= 1'b0;
            MODEM_READY_LEVEL <= 1'b0;
            RX_PULLUP <= 1'b0;
            RX_PULLDOWN <= 1'b0;
            RX_DATA <= 1'b1;
            REMOTE_WAKE_REQ <= 1'b0;
            TX_PIN_OUT <= 1'b0;
            TX_PIN_OE <= 1'b0;
        end else if (CE) begin
            PIN_OUT <= nxt_pin_out;
            PIN_OE <= nxt_pin_oe;
            // Pulls only while an input and not driven in suspend
            MODEM_READY_PULLUP <= mr_is_input && !apply_suspend &&
                modem_ready_pin_cfg_ff[`BIT_PULLUP];
            MODEM_READY_PULLDOWN <= mr_is_input && !apply_suspend &&
                modem_ready_pin_cfg_ff[`BIT_PULLDOWN] &&
                !modem_ready_pin_cfg_ff[`BIT_PULLUP];
            MODEM_READY_LEVEL <= mr_sync_ff;
            // Receive pin pulls stay as set, suspend or not
            RX_PULLUP <= data_pin_cfg_ff[`BIT_PULLUP];
            RX_PULLDOWN <= data_pin_cfg_ff[`BIT_PULLDOWN] &&
                !data_pin_cfg_ff[`BIT_PULLUP];
            RX_DATA <= rx_sync_ff;
            // Falling edge on receive line during suspend asks for wakeup
            REMOTE_WAKE_REQ <= SUSPENDED && GLOBAL_WAKE_EN &&
                data_pin_cfg_ff[`BIT_RX_WAKE] &&
                rx_prev_ff && !rx_sync_ff;
            TX_PIN_OUT <= tx_out;
            TX_PIN_OE <= tx_oe;
        end
    end

endmodule // pin_suspend_config

`default_nettype wire

// [dv/pin_suspend_config_checker.sv]
// Concurrent assertions on the ports of the pin and suspend config block
`default_nettype none
module pin_suspend_config_checker (
    input wire logic CLOCK, // Core clock
    input wire logic RESET, // Synchronous reset
    input wire logic CE, // Clock enable
    input wire logic SUSPENDED, // Link suspended
    input wire logic GLOBAL_WAKE_EN, // Host wakeup enable
    input wire logic [9:0] NORM_OUT, // Normal pad values
    input wire logic [9:0] NORM_OE, // Normal pad enables
    input wire logic [9:0] PIN_OUT, // Pad values
    input wire logic [9:0] PIN_OE, // Pad enables
    input wire logic MODEM_READY_PULLUP, // Modem-ready pull-up
    input wire logic MODEM_READY_PULLDOWN, // Modem-ready pull-down
    input wire logic RX_PULLUP, // Receive pull-up
    input wire logic RX_PULLDOWN, // Receive pull-down
    input wire logic REMOTE_WAKE_REQ, // Wakeup pulse
    input wire logic TX_PIN_OUT, // Transmit pad value
    input wire logic TX_PIN_OE // Transmit pad enable
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Clocking and reset for every property
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    property p_rx_pull; !(RX_PULLUP && RX_PULLDOWN); endproperty
    a_rx_pull: assert property (p_rx_pull)
        else $error("receive pulls both on");
    property p_mr_pull; !(MODEM_READY_PULLUP && MODEM_READY_PULLDOWN); endproperty
    a_mr_pull: assert property (p_mr_pull)
        else $error("modem-ready pulls both on");
    property p_pull_in; MODEM_READY_PULLUP |-> !PIN_OE[7]; endproperty
    a_pull_in: assert property (p_pull_in)
        else $error("modem-ready pull-up while driven");
    property p_wake_one; REMOTE_WAKE_REQ && CE |=> !REMOTE_WAKE_REQ; endproperty
    a_wake_one: assert property (p_wake_one)
        else $error("wakeup pulse too long");
    property p_wake_gate;
        $rose(REMOTE_WAKE_REQ) |-> $past(SUSPENDED) && $past(GLOBAL_WAKE_EN);
    endproperty
    a_wake_gate: assert property (p_wake_gate)
        else $error("wakeup without suspend and global enable");
    property p_drive; (PIN_OUT & ~PIN_OE) == 10'h000; endproperty
    a_drive: assert property (p_drive)
        else $error("pad value high while not driven");
    property p_tx_form; TX_PIN_OUT |-> TX_PIN_OE; endproperty
    a_tx_form: assert property (p_tx_form)
        else $error("transmit pad high while not driven");
    property p_norm;
        $past(!SUSPENDED) && $past(CE) && $past(!RESET) |->
            {PIN_OUT[9:8], PIN_OUT[6:0], PIN_OE[9:8], PIN_OE[6:0]} ==
            $past({NORM_OUT[9:8], NORM_OUT[6:0], NORM_OE[9:8], NORM_OE[6:0]});
    endproperty
    a_norm: assert property (p_norm)
        else $error("pins differ from normal function");
endmodule // pin_suspend_config_checker

bind pin_suspend_config pin_suspend_config_checker u_chk (
    .CLOCK(CLOCK), .RESET(RESET), .CE(CE), .SUSPENDED(SUSPENDED),
    .GLOBAL_WAKE_EN(GLOBAL_WAKE_EN), .NORM_OUT(NORM_OUT), .NORM_OE(NORM_OE),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .RX_PULLUP(RX_PULLUP),
    .MODEM_READY_PULLUP(MODEM_READY_PULLUP), .RX_PULLDOWN(RX_PULLDOWN),
    .MODEM_READY_PULLDOWN(MODEM_READY_PULLDOWN), .TX_PIN_OE(TX_PIN_OE),
    .REMOTE_WAKE_REQ(REMOTE_WAKE_REQ), .TX_PIN_OUT(TX_PIN_OUT));
`default_nettype wire

// [dv/testbench.sv]
// Self-checking testbench for the pin and suspend configuration block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
        error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
    // ==========================================================
    // Signals and scoreboard
    logic CLOCK = 1'b0, RESET = 1'b1, CE = 1'b1, CFG_WR = 1'b0, CFG_RD = 1'b0;
    logic [7:0] CFG_ADDR = 8'h00, CFG_WDATA = 8'h00, CFG_RDATA;
    logic SUSPENDED = 1'b0, GLOBAL_WAKE_EN = 1'b0, MODEM_READY_GPIO_OUT = 1'b0;
    logic [9:0] NORM_OUT = 10'h000, NORM_OE = 10'h000, PIN_OUT, PIN_OE;
    logic TX_DATA = 1'b1, MODEM_READY_IN_PIN = 1'b0, RX_DATA_PIN = 1'b1;
    logic MODEM_READY_PULLUP, MODEM_READY_PULLDOWN, MODEM_READY_LEVEL;
    logic RX_PULLUP, RX_PULLDOWN, RX_DATA, REMOTE_WAKE_REQ;
    logic TX_PIN_OUT, TX_PIN_OE, g;
    int error_cnt = 0, checked = 0, wake_cnt = 0, qk[$], k, i;
    logic [9:0] qv[$], e, eo, ee;
    logic [7:0] u, l, mu, ml, c;
    logic [7:0] mt [0:3] = '{8'hC0, 8'h40, 8'hC1, 8'hC2};
    logic [7:0] dt [0:4] = '{8'h80, 8'h40, 8'hC0, 8'h21, 8'h01};
    event obs;
    string names [0:7] = '{"rdata", "pin_out", "pin_oe", "pulls", "tx_pin",
                           "wake_cnt", "rx_data", "modem_pin"};
    pin_suspend_config u_pin_suspend_config (
        .CLOCK(CLOCK), .RESET(RESET), .CE(CE), .CFG_WR(CFG_WR),
        .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
        .CFG_RDATA(CFG_RDATA), .SUSPENDED(SUSPENDED),
        .GLOBAL_WAKE_EN(GLOBAL_WAKE_EN), .NORM_OUT(NORM_OUT),
        .MODEM_READY_GPIO_OUT(MODEM_READY_GPIO_OUT), .NORM_OE(NORM_OE),
        .TX_DATA(TX_DATA), .MODEM_READY_IN_PIN(MODEM_READY_IN_PIN),
        .RX_DATA_PIN(RX_DATA_PIN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .MODEM_READY_PULLUP(MODEM_READY_PULLUP), .RX_PULLUP(RX_PULLUP),
        .MODEM_READY_PULLDOWN(MODEM_READY_PULLDOWN), .RX_DATA(RX_DATA),
        .MODEM_READY_LEVEL(MODEM_READY_LEVEL), .RX_PULLDOWN(RX_PULLDOWN),
        .REMOTE_WAKE_REQ(REMOTE_WAKE_REQ), .TX_PIN_OUT(TX_PIN_OUT),
        .TX_PIN_OE(TX_PIN_OE));
    // Clock, wakeup pulse counter and result monitor
    always #5 CLOCK = ~CLOCK;
    always @(negedge CLOCK) if (REMOTE_WAKE_REQ === 1'b1) wake_cnt++;
    always @(obs) begin
        while (qk.size() > 0) begin
            k = qk.pop_front();
            e = qv.pop_front();
            `CHK(names[k], e, pick(k))
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [9:0] pick(input int n);
        case (n)
            0: pick = {2'b00, CFG_RDATA};
            1: pick = PIN_OUT & PIN_OE;
            2: pick = PIN_OE;
            3: pick = {6'h00, MODEM_READY_PULLUP, MODEM_READY_PULLDOWN,
                       RX_PULLUP, RX_PULLDOWN};
            4: pick = {8'h00, TX_PIN_OE, TX_PIN_OUT};
            5: pick = wake_cnt[9:0];
            6: pick = {9'h000, RX_DATA};
            default: pick = {8'h00, PIN_OE[7], PIN_OUT[7] & PIN_OE[7]};
        endcase
    endfunction
    task automatic note(input int n, input logic [9:0] v);
        qk.push_back(n);
        qv.push_back(v);
        -> obs;
    endtask
    task automatic settle;
        repeat (3) @(negedge CLOCK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        CFG_WR = 1'b1;
        CFG_ADDR = a;
        CFG_WDATA = d;
        @(negedge CLOCK);
        CFG_WR = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge CLOCK);
        CFG_RD = 1'b1;
        CFG_ADDR = a;
        @(negedge CLOCK);
        CFG_RD = 1'b0;
        @(negedge CLOCK);
        note(0, {2'b00, x});
    endtask
    task automatic chk_norm;
        note(1, NORM_OUT & NORM_OE & 10'h37F);
        note(2, NORM_OE & 10'h37F);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog, about forty-five times the expected run
    initial begin
        #100us;
        error_cnt++;
        tally_and_finish;
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h0000_99F4));
        repeat (12) @(negedge CLOCK);
        RESET = 1'b0;
        for (i = 0; i < 7; i++) rd(8'h2D + i[7:0], 8'h00);
        note(3, 10'h000);
        note(4, 10'h000);
        for (i = 0; i < 4; i++) begin
            c = mt[i];
            g = $urandom;
            MODEM_READY_GPIO_OUT = g;
            wr(8'h2D, c);
            settle;
            note(3, {6'h00, c[7] & ~|c[1:0], c[6] & ~c[7] & ~|c[1:0],
                     2'b00});
            note(7, c[1] ? {8'h00, 1'b1, g} : {8'h00, c[0] & ~g, 1'b0});
        end
        for (i = 0; i < 5; i++) begin
            c = dt[i];
            TX_DATA = $urandom;
            wr(8'h2E, c);
            rd(8'h2E, c);
            note(3, {8'h00, c[7], c[6] & ~c[7]});
            note(4, c[0] ? {8'h00, 1'b1, TX_DATA} : {8'h00, ~TX_DATA, 1'b0});
        end
        wr(8'h2D, 8'hC0);
        wr(8'h2E, 8'hC1);
        for (i = 0; i < 3; i++) begin
            u = $urandom;
            l = $urandom;
            mu = $urandom;
            ml = $urandom | 8'h80;
            NORM_OE = $urandom;
            NORM_OUT = $urandom & NORM_OE;
            wr(8'h2F, u);
            wr(8'h30, l);
            wr(8'h31, mu);
            wr(8'h32, ml);
            rd(8'h32, ml);
            chk_norm;
            SUSPENDED = 1'b1;
            settle;
            eo = {u[7:6], l[5:2], u[3:0]};
            ee = {mu[7:6], ml[5:2], mu[3:0]};
            note(1, eo & ~ee);
            note(2, ~ee | ~eo);
            note(3, 10'h002);
            note(4, {8'h00, 1'b1, TX_DATA});
            wr(8'h32, ml & 8'h7F);
            settle;
            chk_norm;
            note(3, 10'h00A);
            SUSPENDED = 1'b0;
        end
        for (i = 0; i < 5; i++) begin
            wr(8'h2E, (i[0] | i[2]) ? 8'h20 : 8'h00);
            SUSPENDED = (i != 4);
            GLOBAL_WAKE_EN = i[1] | i[2];
            settle;
            wake_cnt = 0;
            RX_DATA_PIN = 1'b0;
            repeat (6) @(negedge CLOCK);
            note(5, (i == 3) ? 10'h001 : 10'h000);
            note(6, 10'h000);
            RX_DATA_PIN = 1'b1;
            settle;
        end
        wr(8'h33, 8'hFF);
        rd(8'h33, 8'h00);
        RESET = 1'b1;
        repeat (2) @(negedge CLOCK);
        RESET = 1'b0;
        rd(8'h2E, 8'h00);
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
